// ==== rtl/ebsc_pkg.sv ====
// shared constants and types of the external bus strobe control block
package ebsc_pkg;
  localparam int ADDR_W = 26;
  localparam int LOW_ADDR_W = 16;
  localparam int HIGH_ADDR_W = 10;
  localparam int DATA_W = 16;
  localparam int NUM_CS = 8;
  localparam int BLOCK_W = 3;
  localparam int SYNC_STAGES = 2;
  // memory area kinds of a request
  localparam logic [1:0] AREA_SRAM = 2'h0;  // sram, external rom, external i/o
  localparam logic [1:0] AREA_PAGE_ROM = 2'h1;
  localparam logic [1:0] AREA_SDRAM = 2'h2;
  // reset values of the pin outputs (strobes are active low)
  localparam logic STROBE_IDLE = 1'b1;
  localparam logic [NUM_CS-1:0] CS_IDLE = 8'hff;
  localparam logic [3:0] FALL_IDLE = 4'hf;
  // positions inside the falling-edge strobe group
  localparam int FALL_WR = 0;
  localparam int FALL_LWR = 1;
  localparam int FALL_UWR = 2;
  localparam int FALL_ADDRESS_LATCH_STROBE = 3;
  typedef enum logic [2:0] {
    idle_state,
    first_cycle_state,
    second_cycle_state,
    third_cycle_state,
    hold_state
  } ebsc_state_type;
endpackage

// ==== rtl/ebsc_sync.sv ====
// two-stage synchroniser for levels entering a clock domain
`timescale 1ns/10ps
module ebsc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] q_nxt;

  // refuse a width that leaves nothing to synchronise
  if (WIDTH < 1) begin : g_width_check
    $error("ebsc_sync: WIDTH must be at least 1");
  end

  // first stage feeds only the second stage
  always_comb begin
    meta_nxt = d;
    q_nxt = meta_r;
  end

  // no reset: the chain flushes within two edges
  always_ff @(posedge clk) begin
    meta_r <= meta_nxt;
    q <= q_nxt;
  end
endmodule

// ==== rtl/ebsc_fall_reg.sv ====
// register clocked on the falling bus clock edge for pin strobes
`timescale 1ns/10ps
module ebsc_fall_reg #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] q_nxt;

  // refuse a width that leaves no strobe to register
  if (WIDTH < 1) begin : g_width_check
    $error("ebsc_fall_reg: WIDTH must be at least 1");
  end

  // reset is already in the bus clock domain
  always_comb begin
    q_nxt = rst ? RESET_VAL : d;
  end

  // half a bus clock after the rising-edge state change
  always_ff @(negedge clk) begin
    q <= q_nxt;
  end
endmodule

// ==== rtl/ebsc_top.sv ====
// external bus strobe control: request crossing, bus cycle sequencer, pin outputs
//
// Function
// - low 16 address bits on lower outputs
// - upper 10 address bits on upper outputs
// - address updates in T1, held in idle
// - shared bus: address then data, or data
// - chip select n active for block n
// - flyby write strobe marks i/o write
// - flyby read strobe marks i/o read
// - strobe enable extends i/o strobes to sram
// - low-byte write strobe: fall T1 to T2, multiplexed fall T2 to T3
// - high-byte write strobe: fall T1 to T2, multiplexed fall T2 to T3
// - sdram lane masks: one per byte
// - byte enables for low and high lanes
// - read strobe for sram, rom, io, page rom
// - write enable marks sdram writes
// - write strobe: fall T1 to fall T2, multiplexed fall T2 to fall T3
// - address latch strobe low T1, high T3
// - cycle start active one clock per cycle
// - wait sampled on rising edge, separate mode
// - separate or multiplexed bus selectable
// - hold: finish cycle, float, acknowledge
`timescale 1ns/10ps
module ebsc_top
  import ebsc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ext_bus_clock,
  // system-side request port
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic req_write,
  input wire logic [1:0] req_be,
  input wire logic [DATA_W-1:0] req_wdata,
  input wire logic [1:0] req_area,
  input wire logic [BLOCK_W-1:0] req_block,
  input wire logic req_flyby,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  // static configuration levels from the system side
  input wire logic mux_mode,
  input wire logic io_strobe_enable_bit,
  // bus pins
  output logic [LOW_ADDR_W-1:0] lower_address_outputs,
  output logic [HIGH_ADDR_W-1:0] upper_address_outputs,
  output logic address_oe,
  input wire logic [DATA_W-1:0] shared_addr_data_bus_in,
  output logic [DATA_W-1:0] shared_addr_data_bus_out,
  output logic shared_addr_data_bus_oe,
  output logic [NUM_CS-1:0] block_chip_selects_n,
  output logic control_oe,
  output logic flyby_io_write_strobe_n,
  output logic flyby_io_read_strobe_n,
  output logic write_strobe_n,
  output logic low_byte_write_strobe_n,
  output logic high_byte_write_strobe_n,
  output logic low_lane_data_mask,
  output logic high_lane_data_mask,
  output logic low_byte_enable_n,
  output logic high_byte_enable_n,
  output logic read_strobe_n,
  output logic write_enable_n,
  output logic address_latch_strobe_n,
  output logic cycle_start_status_n,
  input wire logic ext_wait_n,
  input wire logic hold_request_in_n,
  output logic hold_acknowledge_out_n
);

  // ---------------- system clock domain ----------------
  logic busy_r, busy_nxt;
  logic req_tog_r, req_tog_nxt;
  logic done_seen_r, done_seen_nxt;
  logic rsp_valid_r, rsp_valid_nxt;
  logic [DATA_W-1:0] rsp_rdata_r, rsp_rdata_nxt;
  logic [ADDR_W-1:0] cap_addr_r, cap_addr_nxt;
  logic cap_write_r, cap_write_nxt;
  logic [1:0] cap_be_r, cap_be_nxt;
  logic [DATA_W-1:0] cap_wdata_r, cap_wdata_nxt;
  logic [1:0] cap_area_r, cap_area_nxt;
  logic [BLOCK_W-1:0] cap_block_r, cap_block_nxt;
  logic cap_flyby_r, cap_flyby_nxt;
  logic done_tog_s;

  // link-side signals
  logic rst_link;
  logic req_tog_s;
  logic mux_s;
  logic io_en_s;
  logic wait_s;
  logic hold_s;
  logic done_tog_r, done_tog_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;

  // one request in flight: the captured words stay still until done returns
  assign req_ready = ~busy_r;
  assign rsp_valid = rsp_valid_r;
  assign rsp_rdata = rsp_rdata_r;

  ebsc_sync #(.WIDTH(1)) u_done_sync (
    .clk(clk_sys),
    .d(done_tog_r),
    .q(done_tog_s)
  );

  // request capture and completion detect
  always_comb begin
    busy_nxt = busy_r;
    req_tog_nxt = req_tog_r;
    done_seen_nxt = done_seen_r;
    rsp_valid_nxt = 1'b0;
    rsp_rdata_nxt = rsp_rdata_r;
    cap_addr_nxt = cap_addr_r;
    cap_write_nxt = cap_write_r;
    cap_be_nxt = cap_be_r;
    cap_wdata_nxt = cap_wdata_r;
    cap_area_nxt = cap_area_r;
    cap_block_nxt = cap_block_r;
    cap_flyby_nxt = cap_flyby_r;
    if (req_valid && !busy_r) begin
      busy_nxt = 1'b1;
      req_tog_nxt = ~req_tog_r;
      cap_addr_nxt = req_addr;
      cap_write_nxt = req_write;
      cap_be_nxt = req_be;
      cap_wdata_nxt = req_wdata;
      cap_area_nxt = req_area;
      cap_block_nxt = req_block;
      cap_flyby_nxt = req_flyby;
    end
    // read data is stable: link changes it only before toggling done
    if (done_tog_s != done_seen_r) begin
      done_seen_nxt = done_tog_s;
      busy_nxt = 1'b0;
      rsp_valid_nxt = 1'b1;
      rsp_rdata_nxt = rdata_r;
    end
    if (rst) begin
      busy_nxt = 1'b0;
      req_tog_nxt = 1'b0;
      done_seen_nxt = 1'b0;
      rsp_rdata_nxt = '0;
      cap_addr_nxt = '0;
      cap_write_nxt = 1'b0;
      cap_be_nxt = '0;
      cap_wdata_nxt = '0;
      cap_area_nxt = AREA_SRAM;
      cap_block_nxt = '0;
      cap_flyby_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    busy_r <= busy_nxt;
    req_tog_r <= req_tog_nxt;
    done_seen_r <= done_seen_nxt;
    rsp_valid_r <= rsp_valid_nxt;
    rsp_rdata_r <= rsp_rdata_nxt;
    cap_addr_r <= cap_addr_nxt;
    cap_write_r <= cap_write_nxt;
    cap_be_r <= cap_be_nxt;
    cap_wdata_r <= cap_wdata_nxt;
    cap_area_r <= cap_area_nxt;
    cap_block_r <= cap_block_nxt;
    cap_flyby_r <= cap_flyby_nxt;
  end

  // ---------------- bus clock domain ----------------
  // reset, toggle and config levels brought onto the bus clock
  ebsc_sync #(.WIDTH(4)) u_link_sync (
    .clk(ext_bus_clock),
    .d({rst, req_tog_r, mux_mode, io_strobe_enable_bit}),
    .q({rst_link, req_tog_s, mux_s, io_en_s})
  );

  // asynchronous pins; a late wait edge is simply seen one clock later
  // async wait tolerated
  ebsc_sync #(.WIDTH(2)) u_pin_sync (
    .clk(ext_bus_clock),
    .d({~ext_wait_n, ~hold_request_in_n}),
    .q({wait_s, hold_s})
  );

  ebsc_state_type state_r, state_nxt;
  logic seen_r, seen_nxt;
  logic [LOW_ADDR_W-1:0] low_addr_r, low_addr_nxt;
  logic [HIGH_ADDR_W-1:0] high_addr_r, high_addr_nxt;
  logic cyc_write_r, cyc_write_nxt;
  logic [1:0] cyc_be_r, cyc_be_nxt;
  logic [DATA_W-1:0] cyc_wdata_r, cyc_wdata_nxt;
  logic [1:0] cyc_area_r, cyc_area_nxt;
  logic [BLOCK_W-1:0] cyc_block_r, cyc_block_nxt;
  logic cyc_flyby_r, cyc_flyby_nxt;
  logic cyc_mux_r, cyc_mux_nxt;
  logic [NUM_CS-1:0] cs_n_r, cs_n_nxt;
  logic cycle_start_status_n_r, cycle_start_status_n_nxt;
  logic rd_n_r, rd_n_nxt;
  logic we_n_r, we_n_nxt;
  logic lbe_n_r, lbe_n_nxt;
  logic ube_n_r, ube_n_nxt;
  logic [1:0] dqm_r, dqm_nxt;
  logic flyby_io_write_strobe_n_r, flyby_io_write_strobe_n_nxt;
  logic flyby_io_read_strobe_n_r, flyby_io_read_strobe_n_nxt;
  logic [DATA_W-1:0] ad_out_r, ad_out_nxt;
  logic ad_oe_r, ad_oe_nxt;
  logic bus_oe_r, bus_oe_nxt;
  logic hlda_n_r, hlda_n_nxt;
  logic pending;
  logic wait_eff;
  logic in_cycle;
  logic sram_wr;
  logic [3:0] fall_d;
  logic [3:0] fall_q;

  // wait states only exist in separate bus mode
  // wait gating
  assign wait_eff = wait_s & ~cyc_mux_r;
  assign pending = (req_tog_s != seen_r);
  assign sram_wr = cyc_write_r && (cyc_area_r == AREA_SRAM);

  // sequencer, cycle fields and rising-edge pin values
  always_comb begin
    state_nxt = state_r;
    seen_nxt = seen_r;
    done_tog_nxt = done_tog_r;
    rdata_nxt = rdata_r;
    low_addr_nxt = low_addr_r;
    high_addr_nxt = high_addr_r;
    cyc_write_nxt = cyc_write_r;
    cyc_be_nxt = cyc_be_r;
    cyc_wdata_nxt = cyc_wdata_r;
    cyc_area_nxt = cyc_area_r;
    cyc_block_nxt = cyc_block_r;
    cyc_flyby_nxt = cyc_flyby_r;
    cyc_mux_nxt = cyc_mux_r;
    case (state_r)
      idle_state: begin
        // hold taken at once when idle
        if (hold_s) begin
          state_nxt = hold_state;
        end else if (pending) begin
          state_nxt = first_cycle_state;
        end
      end
      first_cycle_state: begin
        state_nxt = second_cycle_state;
      end
      second_cycle_state: begin
        // data wait extends the second state
        if (!wait_eff) begin
          state_nxt = third_cycle_state;
          rdata_nxt = cyc_write_r ? rdata_r : shared_addr_data_bus_in;
        end
      end
      third_cycle_state: begin
        done_tog_nxt = ~done_tog_r;
        // hold only after the current cycle ends
        if (hold_s) begin
          state_nxt = hold_state;
        end else begin
          state_nxt = idle_state;
        end
      end
      hold_state: begin
        if (!hold_s) begin
          state_nxt = idle_state;
        end
      end
      default: begin
        state_nxt = idle_state;
      end
    endcase
    // address loads on the edge that enters the first state
    if (state_nxt == first_cycle_state) begin
      seen_nxt = req_tog_s;
      low_addr_nxt = cap_addr_r[LOW_ADDR_W-1:0];
      high_addr_nxt = cap_addr_r[ADDR_W-1:LOW_ADDR_W];
      cyc_write_nxt = cap_write_r;
      cyc_be_nxt = cap_be_r;
      cyc_wdata_nxt = cap_wdata_r;
      cyc_area_nxt = cap_area_r;
      cyc_block_nxt = cap_block_r;
      cyc_flyby_nxt = cap_flyby_r;
      cyc_mux_nxt = mux_s;
    end
    if (rst_link) begin
      state_nxt = idle_state;
      seen_nxt = 1'b0;
      done_tog_nxt = 1'b0;
      rdata_nxt = '0;
      low_addr_nxt = '0;
      high_addr_nxt = '0;
      cyc_write_nxt = 1'b0;
      cyc_be_nxt = '0;
      cyc_wdata_nxt = '0;
      cyc_area_nxt = AREA_SRAM;
      cyc_block_nxt = '0;
      cyc_flyby_nxt = 1'b0;
      cyc_mux_nxt = 1'b0;
    end
  end

  // pin levels follow the next state so they change on the same rising edge
  always_comb begin
    in_cycle = (state_nxt == first_cycle_state) || (state_nxt == second_cycle_state) ||
               (state_nxt == third_cycle_state);
    cs_n_nxt = CS_IDLE;
    cycle_start_status_n_nxt = STROBE_IDLE;
    rd_n_nxt = STROBE_IDLE;
    we_n_nxt = STROBE_IDLE;
    lbe_n_nxt = STROBE_IDLE;
    ube_n_nxt = STROBE_IDLE;
    dqm_nxt = 2'h3;
    flyby_io_write_strobe_n_nxt = STROBE_IDLE;
    flyby_io_read_strobe_n_nxt = STROBE_IDLE;
    ad_out_nxt = ad_out_r;
    ad_oe_nxt = 1'b0;
    bus_oe_nxt = (state_nxt != hold_state);
    hlda_n_nxt = (state_nxt != hold_state);
    if (in_cycle) begin
      // chip select of the addressed block
      cs_n_nxt = ~(8'h01 << cyc_block_nxt);
      cycle_start_status_n_nxt = (state_nxt != first_cycle_state);
      rd_n_nxt = ~(!cyc_write_nxt && (cyc_area_nxt != AREA_SDRAM));
      we_n_nxt = ~(cyc_write_nxt && (cyc_area_nxt == AREA_SDRAM));
      lbe_n_nxt = ~cyc_be_nxt[0];
      ube_n_nxt = ~cyc_be_nxt[1];
      // masks active for unused lanes of an sdram cycle
      if (cyc_area_nxt == AREA_SDRAM) begin
        dqm_nxt = ~cyc_be_nxt;
      end
      // flyby write, or enabled on sram
      flyby_io_write_strobe_n_nxt = ~(cyc_write_nxt && (cyc_flyby_nxt ||
                     (io_en_s && (cyc_area_nxt == AREA_SRAM))));
      // flyby read, or enabled on sram
      flyby_io_read_strobe_n_nxt = ~(!cyc_write_nxt && (cyc_flyby_nxt ||
                     (io_en_s && (cyc_area_nxt == AREA_SRAM))));
      if (cyc_mux_nxt && (state_nxt == first_cycle_state)) begin
        ad_out_nxt = low_addr_nxt;
        ad_oe_nxt = 1'b1;
      end else if (cyc_write_nxt) begin
        ad_out_nxt = cyc_wdata_nxt;
        ad_oe_nxt = 1'b1;
      end
    end
    if (rst_link) begin
      ad_out_nxt = '0;
      bus_oe_nxt = 1'b1;
      hlda_n_nxt = STROBE_IDLE;
    end
  end

  always_ff @(posedge ext_bus_clock) begin
    state_r <= state_nxt;
    seen_r <= seen_nxt;
    done_tog_r <= done_tog_nxt;
    rdata_r <= rdata_nxt;
    low_addr_r <= low_addr_nxt;
    high_addr_r <= high_addr_nxt;
    cyc_write_r <= cyc_write_nxt;
    cyc_be_r <= cyc_be_nxt;
    cyc_wdata_r <= cyc_wdata_nxt;
    cyc_area_r <= cyc_area_nxt;
    cyc_block_r <= cyc_block_nxt;
    cyc_flyby_r <= cyc_flyby_nxt;
    cyc_mux_r <= cyc_mux_nxt;
    cs_n_r <= cs_n_nxt;
    cycle_start_status_n_r <= cycle_start_status_n_nxt;
    rd_n_r <= rd_n_nxt;
    we_n_r <= we_n_nxt;
    lbe_n_r <= lbe_n_nxt;
    ube_n_r <= ube_n_nxt;
    dqm_r <= dqm_nxt;
    flyby_io_write_strobe_n_r <= flyby_io_write_strobe_n_nxt;
    flyby_io_read_strobe_n_r <= flyby_io_read_strobe_n_nxt;
    ad_out_r <= ad_out_nxt;
    ad_oe_r <= ad_oe_nxt;
    bus_oe_r <= bus_oe_nxt;
    hlda_n_r <= hlda_n_nxt;
  end

  // falling-edge strobes: sampled half a clock after each state change
  always_comb begin
    fall_d = FALL_IDLE;
    // on at T1 fall, off at the last T2 fall
    if ((state_r == first_cycle_state) || ((state_r == second_cycle_state) && wait_eff)) begin
      if (sram_wr && !cyc_mux_r) begin
        fall_d[FALL_WR] = 1'b0;
        fall_d[FALL_LWR] = ~cyc_be_r[0];
        fall_d[FALL_UWR] = ~cyc_be_r[1];
      end
    end
    // multiplexed writes strobe only in the data phase
    if ((state_r == second_cycle_state) && sram_wr && cyc_mux_r) begin
      fall_d[FALL_WR] = 1'b0;
      fall_d[FALL_LWR] = ~cyc_be_r[0];
      fall_d[FALL_UWR] = ~cyc_be_r[1];
    end
    // latch strobe low from T1 fall until T3 fall
    if ((state_r == first_cycle_state) || (state_r == second_cycle_state)) begin
      fall_d[FALL_ADDRESS_LATCH_STROBE] = 1'b0;
    end
  end

  ebsc_fall_reg #(.WIDTH(4), .RESET_VAL(FALL_IDLE)) u_fall (
    .clk(ext_bus_clock),
    .rst(rst_link),
    .d(fall_d),
    .q(fall_q)
  );

  // pin drive, all from flip-flops
  // lower address group
  assign lower_address_outputs = low_addr_r;
  assign upper_address_outputs = high_addr_r;
  assign address_oe = bus_oe_r;
  assign control_oe = bus_oe_r;
  assign shared_addr_data_bus_out = ad_out_r;
  assign shared_addr_data_bus_oe = ad_oe_r;
  assign block_chip_selects_n = cs_n_r;
  assign flyby_io_write_strobe_n = flyby_io_write_strobe_n_r;
  assign flyby_io_read_strobe_n = flyby_io_read_strobe_n_r;
  assign write_strobe_n = fall_q[FALL_WR];
  assign low_byte_write_strobe_n = fall_q[FALL_LWR];
  assign high_byte_write_strobe_n = fall_q[FALL_UWR];
  assign low_lane_data_mask = dqm_r[0];
  assign high_lane_data_mask = dqm_r[1];
  assign low_byte_enable_n = lbe_n_r;
  assign high_byte_enable_n = ube_n_r;
  assign read_strobe_n = rd_n_r;
  assign write_enable_n = we_n_r;
  assign address_latch_strobe_n = fall_q[FALL_ADDRESS_LATCH_STROBE];
  assign cycle_start_status_n = cycle_start_status_n_r;
  assign hold_acknowledge_out_n = hlda_n_r;
endmodule

// ==== verif/ebsc_props.sv ====
// bus-side assertions of the external bus strobe control block
`timescale 1ns/10ps
module ebsc_props
  import ebsc_pkg::*;
(
  input wire logic ext_bus_clock,
  input wire logic rst,
  input wire logic mux_mode,
  input wire logic [LOW_ADDR_W-1:0] lower_address_outputs,
  input wire logic [HIGH_ADDR_W-1:0] upper_address_outputs,
  input wire logic [NUM_CS-1:0] block_chip_selects_n,
  input wire logic write_strobe_n,
  input wire logic low_byte_write_strobe_n,
  input wire logic low_byte_enable_n,
  input wire logic low_lane_data_mask,
  input wire logic high_lane_data_mask,
  input wire logic read_strobe_n,
  input wire logic write_enable_n,
  input wire logic address_latch_strobe_n,
  input wire logic cycle_start_status_n
);
  // all checks live in the bus domain, so clock and reset are given once
  default clocking @(posedge ext_bus_clock);
  endclocking
  default disable iff (rst);
  // no chip select active means the idle or hold state
  logic idle;
  logic [ADDR_W-1:0] addr_pins;
  assign idle = &block_chip_selects_n;
  assign addr_pins = {upper_address_outputs, lower_address_outputs};
  sequence start_s;
    !cycle_start_status_n;
  endsequence
  sequence body_s;
    !idle [*3];
  endsequence
  sequence sep_wr_s;
    start_s ##0 (!write_strobe_n && !mux_mode);
  endsequence
  cycle_start_status_single_a:
    assert property (start_s |-> !idle ##1 cycle_start_status_n)
    else $error("cycle start status active for more than one clock");
  cycle_steps_a:
    assert property (start_s |-> body_s ##[1:40] idle)
    else $error("bus cycle shorter than three states or never ends");
  addr_hold_a:
    assert property (idle |-> $stable(addr_pins))
    else $error("address pins changed in the idle state");
  cs_onehot_a:
    assert property (!idle |-> $onehot(~block_chip_selects_n))
    else $error("more than one chip select active");
  address_latch_strobe_window_a:
    assert property (start_s |-> !address_latch_strobe_n [*2])
    else $error("address latch strobe not low through the first two states");
  wr_release_a:
    assert property (sep_wr_s |-> ##[1:10] (write_strobe_n && !idle))
    else $error("write strobe not released before the cycle ends");
  lane_write_a:
    assert property (!low_byte_write_strobe_n |-> !low_byte_enable_n && !idle)
    else $error("low byte write strobe without its lane enable");
  read_excl_a:
    assert property (!read_strobe_n |-> !idle && write_strobe_n && write_enable_n)
    else $error("read strobe outside a read cycle");
  mask_idle_a:
    assert property (idle |-> low_lane_data_mask && high_lane_data_mask)
    else $error("data mask released outside a bus cycle");
endmodule

bind ebsc_top ebsc_props ebsc_props_inst (.*);

// ==== verif/ebsc_mem_model.sv ====
// behavioural sram on the far side of the bus, able to answer slowly through wait
`timescale 1ns/10ps
module ebsc_mem_model
  import ebsc_pkg::*;
(
  input wire logic ext_bus_clock,
  input wire logic [LOW_ADDR_W-1:0] lower_address_outputs,
  input wire logic [NUM_CS-1:0] block_chip_selects_n,
  input wire logic read_strobe_n,
  input wire logic low_byte_write_strobe_n,
  input wire logic high_byte_write_strobe_n,
  input wire logic [DATA_W-1:0] shared_addr_data_bus_out,
  input wire logic shared_addr_data_bus_oe,
  input wire logic [31:0] wait_len,
  output logic [DATA_W-1:0] shared_addr_data_bus_in,
  output logic ext_wait_n
);
  logic [DATA_W-1:0] mem [256];
  logic [DATA_W-1:0] drv = 16'h0000;
  logic [7:0] idx;
  int cnt = 0;
  assign idx = lower_address_outputs[8:1];
  // lanes captured as their strobe releases
  always @(posedge low_byte_write_strobe_n) mem[idx][7:0] = shared_addr_data_bus_out[7:0];
  always @(posedge high_byte_write_strobe_n) mem[idx][15:8] = shared_addr_data_bus_out[15:8];
  // data while read strobe is low, otherwise a pattern that never holds still
  always @(posedge ext_bus_clock) drv <= read_strobe_n ? ~drv : mem[idx];
  // the wire follows whichever side enables it
  assign shared_addr_data_bus_in = shared_addr_data_bus_oe ? shared_addr_data_bus_out : drv;
  // wait set up ahead of the cycle: the two-flop sync needs it two clocks early
  always @(posedge ext_bus_clock) cnt <= &block_chip_selects_n ? 0 : cnt + 1;
  assign ext_wait_n = !(wait_len > 0 && (&block_chip_selects_n || cnt < wait_len));
endmodule

// ==== verif/tb_external_bus_strobe_control.sv ====
// self-checking bench for the external bus strobe control block
`timescale 1ns/10ps
module tb_external_bus_strobe_control;
  import ebsc_pkg::*;
  logic clk_sys = 1'b0;
  logic ext_bus_clock = 1'b0;
  logic rst = 1'b1;
  logic req_valid, req_ready, req_write, req_flyby, rsp_valid, mux_mode, io_strobe_enable_bit;
  logic [ADDR_W-1:0] req_addr, cap_a;
  logic [1:0] req_be, req_area;
  logic [DATA_W-1:0] req_wdata, rsp_rdata, shared_addr_data_bus_in, shared_addr_data_bus_out;
  logic [DATA_W-1:0] rd_q;
  logic [BLOCK_W-1:0] req_block;
  logic [LOW_ADDR_W-1:0] lower_address_outputs;
  logic [HIGH_ADDR_W-1:0] upper_address_outputs;
  logic [NUM_CS-1:0] block_chip_selects_n, cs_seen;
  logic address_oe, shared_addr_data_bus_oe, control_oe, flyby_io_write_strobe_n;
  logic flyby_io_read_strobe_n, write_strobe_n, low_byte_write_strobe_n, high_byte_write_strobe_n;
  logic low_lane_data_mask, high_lane_data_mask, low_byte_enable_n, high_byte_enable_n;
  logic read_strobe_n, write_enable_n, address_latch_strobe_n, cycle_start_status_n;
  logic ext_wait_n, hold_request_in_n, hold_acknowledge_out_n;
  logic [10:0] seen;
  int wait_len, failures, total_checks, cs_cnt, bc_cnt;
  ebsc_top ebsc_top_inst (.*);
  ebsc_mem_model ebsc_mem_model_inst (.*);
  // clocks of unrelated phase; the bus clock starts off the system grid
  initial forever #20 clk_sys = ~clk_sys;
  initial begin
    #1.7;
    forever #3 ext_bus_clock = ~ext_bus_clock;
  end
  // per-cycle record of the pins; bits are rd wr lwr uwr we flyby_io_write_strobe flyby_io_read_strobe lbe ube low_lane_data_mask high_lane_data_mask
  always @(posedge ext_bus_clock) begin
    if (!(&block_chip_selects_n)) begin
      cs_cnt++;
      cs_seen &= block_chip_selects_n;
      if (!cycle_start_status_n) bc_cnt++;
      if (!cycle_start_status_n) cap_a = {upper_address_outputs, lower_address_outputs};
      seen |= ~{read_strobe_n, write_strobe_n, low_byte_write_strobe_n, high_byte_write_strobe_n,
                write_enable_n, flyby_io_write_strobe_n, flyby_io_read_strobe_n,
                low_byte_enable_n, high_byte_enable_n, low_lane_data_mask, high_lane_data_mask};
    end
  end
  task automatic end_of_test;
    if (failures == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one request held until taken, then a bounded wait for its response
  task automatic xfer(logic [ADDR_W-1:0] a, logic w, logic [1:0] be, logic [DATA_W-1:0] d);
    int n;
    n = 0;
    cs_cnt = 0;
    bc_cnt = 0;
    seen = '0;
    cs_seen = '1;
    req_addr = a;
    req_write = w;
    req_be = be;
    req_wdata = d;
    req_valid = 1'b1;
    while (req_ready !== 1'b1 && n < 400) begin
      @(posedge clk_sys);
      #1 n++;
    end
    @(posedge clk_sys);
    #1 req_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 800) begin
      @(posedge clk_sys);
      #1 n++;
    end
    chk("response", 1, 32'(rsp_valid));
    rd_q = rsp_rdata;
    @(posedge clk_sys);
    #1;
  endtask
  // every block written and read back
  task automatic t_blocks;
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] d;
    logic [NUM_CS-1:0] cse;
    for (int b = 0; b < NUM_CS; b++) begin
      a = {10'(b * 37 + 5), 16'(b * 2 + 16'h0a40)};
      d = 16'h5ac3 ^ 16'(b * 16'h1111);
      cse = ~(8'h01 << b);
      req_block = 3'(b);
      xfer(a, 1'b1, 2'h3, d);
      chk("address", 32'(a), 32'(cap_a));
      chk("chip select", 32'(cse), 32'(cs_seen));
      chk("cycle length", 3, 32'(cs_cnt));
      chk("start pulses", 1, 32'(bc_cnt));
      chk("write strobes", 32'h38c, 32'(seen));
      xfer(a, 1'b0, 2'h3, 16'h0000);
      chk("read data", 32'(d), 32'(rd_q));
      chk("read strobes", 32'h40c, 32'(seen));
    end
  endtask
  // single-lane writes touch only their byte
  task automatic t_lanes;
    req_block = 3'h2;
    xfer(26'h0000a80, 1'b1, 2'h3, 16'h0000);
    xfer(26'h0000a80, 1'b1, 2'h1, 16'hbeef);
    chk("low lane strobes", 32'h308, 32'(seen));
    xfer(26'h0000a80, 1'b1, 2'h2, 16'h1234);
    chk("high lane strobes", 32'h284, 32'(seen));
    xfer(26'h0000a80, 1'b0, 2'h3, 16'h0000);
    chk("merged lanes", 32'h12ef, 32'(rd_q));
  endtask
  // i/o strobes for flyby cycles and under the enable bit, all combinations
  task automatic t_io;
    logic [2:0] k;
    for (int i = 0; i < 8; i++) begin
      k = 3'(i);
      io_strobe_enable_bit = k[2];
      req_flyby = k[1];
      xfer(26'h0000a80, k[0], 2'h3, 16'h12ef);
      chk("io strobes", (k[2] | k[1]) ? (k[0] ? 32'h20 : 32'h10) : 32'h0,
          32'(seen & 11'h030));
    end
    io_strobe_enable_bit = 1'b0;
    req_flyby = 1'b0;
  endtask
  // sdram write enable and lane masks, then a page rom read
  task automatic t_areas;
    req_area = AREA_SDRAM;
    xfer(26'h0001000, 1'b1, 2'h1, 16'h00aa);
    chk("sdram write", 32'h042, 32'(seen & 11'h643));
    xfer(26'h0001000, 1'b0, 2'h3, 16'h0000);
    chk("sdram read", 32'h003, 32'(seen & 11'h643));
    req_area = AREA_PAGE_ROM;
    xfer(26'h0001000, 1'b0, 2'h3, 16'h0000);
    chk("page rom read", 32'h400, 32'(seen & 11'h640));
    req_area = AREA_SRAM;
  endtask
  // wait stretches separate cycles and is ignored when multiplexed
  task automatic t_wait;
    req_block = 3'h1;
    wait_len = 6;
    xfer(26'h0000b00, 1'b1, 2'h3, 16'h9c5a);
    chk("stretched write", 1, 32'(cs_cnt > 3));
    mux_mode = 1'b1;
    xfer(26'h0000b20, 1'b1, 2'h3, 16'h36e1);
    xfer(26'h0000b20, 1'b0, 2'h3, 16'h0000);
    chk("mux read data", 32'h36e1, 32'(rd_q));
    chk("mux cycle length", 3, 32'(cs_cnt));
    mux_mode = 1'b0;
    xfer(26'h0000b00, 1'b0, 2'h3, 16'h0000);
    chk("waited read data", 32'h9c5a, 32'(rd_q));
    chk("stretched read", 1, 32'(cs_cnt > 3));
    wait_len = 0;
  endtask
  // bus floated under hold, a request waits until hold ends
  task automatic t_hold;
    int n;
    n = 0;
    hold_request_in_n = 1'b0;
    while (hold_acknowledge_out_n !== 1'b0 && n < 50) begin
      @(posedge clk_sys);
      #1 n++;
    end
    chk("hold acknowledge", 0, 32'(hold_acknowledge_out_n));
    chk("bus floated", 0, 32'({address_oe, control_oe, shared_addr_data_bus_oe}));
    fork
      xfer(26'h0000b00, 1'b0, 2'h3, 16'h0000);
      begin
        repeat (20) @(posedge clk_sys);
        #1 chk("no cycle in hold", 0, 32'(bc_cnt));
        hold_request_in_n = 1'b1;
      end
    join
    chk("read after hold", 32'h9c5a, 32'(rd_q));
    chk("hold released", 1, 32'(hold_acknowledge_out_n));
  endtask
  // reset, then the scenarios in turn
  initial begin
    {req_valid, req_write, req_flyby, mux_mode, io_strobe_enable_bit} = 5'h00;
    hold_request_in_n = 1'b1;
    req_addr = '0;
    req_be = 2'h3;
    req_wdata = '0;
    req_area = AREA_SRAM;
    req_block = 3'h0;
    repeat (20) @(posedge clk_sys);
    #1 rst = 1'b0;
    chk("ready after reset", 1, 32'(req_ready));
    t_blocks();
    t_lanes();
    t_io();
    t_areas();
    t_wait();
    t_hold();
    end_of_test();
  end
  // a hung handshake ends the run; the scenarios need well under a tenth of this
  initial begin
    #400000;
    failures++;
    end_of_test();
  end
endmodule
